// ### verilog/disp_ctrl_pkg.sv
// constants for the display drive control and watchdog strap block
// assumes an avalon-mm byte-lane register slave on a 32-bit data bus
package disp_ctrl_pkg;
    // register byte addresses (word aligned except 0x2021, the enable and rate byte inside the 0x2020 word)
    localparam logic [15:0] boost_ctrl_addr = 16'h2020;
    localparam logic [15:0] enable_rate_addr = 16'h2021;
    localparam logic [15:0] enable_rate_word_addr = 16'h2024;
    localparam logic [15:0] status_addr = 16'h2028;
    // field positions
    localparam int boost_en_bit = 7;
    localparam int out_en_bit = 5;
    localparam int rate_lsb = 0;
    localparam int rate_msb = 1;
    // reset values
    localparam logic [7:0] boost_ctrl_reset = 8'h00;
    localparam logic [7:0] enable_rate_reset = 8'h00;
    // base divider of the converter clock
    localparam int base_div = 128;
    localparam int base_rate_hz = 38400;
    // power-of-two exponent for rate code 00; code n gives exponent 9-n
    localparam int rate_exp_max = 9;
    // boost drive half period in converter clocks
    localparam int boost_half_div = 8;
endpackage : disp_ctrl_pkg

// ### verilog/disp_ctrl.sv
// display drive control: output gating, boost pump drive, rate divider,
// watchdog strap sense. assumes converter_clock and strap come from pins.
//
// Behaviour
// R1: enable bit low forces bias rails, commons and segments to ground.
// R2: boost enable bit switches the charge pump, read and write.
// R3: rate code selects converter clock over 128 then 2^9..2^6.
// R4: base rate nominally 38400 Hz before the power-of-two division.
// R5: software normally sets rate code 01, about 150 Hz.
// R6: watchdog held off while strap pin is at the supply level.
// R7: programmer runs only while strap is tied high.
// R8: boost enable produces an alternating waveform on the drive pin.
// R9: software uses read-modify-write on the shared byte.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module disp_ctrl
    import disp_ctrl_pkg::*;
#(
    parameter int num_com = 4,
    parameter int num_seg = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins from outside
    input wire logic converter_clock,
    input wire logic watchdog_strap_pin,
    // panel drive, from the display engine
    input wire logic [num_com-1:0] com_raw,
    input wire logic [num_seg-1:0] seg_raw,
    input wire logic [2:0] bias_raw,
    output logic [num_com-1:0] com_out,
    output logic [num_seg-1:0] seg_out,
    output logic bias_rail_top,
    output logic bias_rail_mid,
    output logic bias_rail_low,
    // pump, watchdog and display rate
    output logic boost_drive_pin,
    output logic watchdog_enable,
    output logic display_tick
);

    // register state
    // the boost byte holds only the pump enable of interest here;
    // the other bits are kept as plain storage so software reads back
    // what it wrote, which read-modify-write depends on
    logic [7:0] boost_ctrl_reg;
    // the enable and rate byte: output enable and the two rate bits,
    // the rest stored and read back unchanged
    logic [7:0] enable_rate_reg;

    // fields picked out of the two bytes
    logic display_output_enable;
    logic display_boost_enable;
    logic [1:0] display_rate_select;

    // bus handshake state
    // waitrequest comes from this flop so the port is registered;
    // it idles high and drops for exactly one cycle per access
    logic wait_reg;

    // address decode results
    logic hit_boost;
    logic hit_rate;
    logic hit_status;

    // read data before it is registered
    logic [31:0] read_next;

    // synchronisers for pins
    // the converter clock needs a third stage for edge detection;
    // only the second and third stages feed logic
    logic [2:0] cclk_sync;
    // the strap pin is a slow level; two stages are enough
    logic [1:0] strap_sync;

    // dividers
    // base divider: 128 converter clock rising edges per base tick
    logic [6:0] base_cnt;
    logic base_tick;
    // rate divider: counts base ticks up to the selected power of two
    logic [rate_exp_max-1:0] rate_cnt;
    logic [rate_exp_max-1:0] rate_mask;
    // pump drive: half period counter and current phase
    logic [3:0] boost_cnt;
    logic boost_phase;

    // converter clock rising edge seen in the sys_clk domain
    logic cclk_rise;

    // field extraction from the stored bytes
    assign display_output_enable = enable_rate_reg[out_en_bit];
    assign display_boost_enable = boost_ctrl_reg[boost_en_bit];
    assign display_rate_select = enable_rate_reg[rate_msb:rate_lsb];

    // address decode: 0x2020 word holds both bytes (lane 0 and lane 1)
    // the 0x2024 word is an aligned alias of the enable and rate byte
    assign hit_boost = (address == boost_ctrl_addr);
    assign hit_rate = (address == enable_rate_word_addr);
    assign hit_status = (address == status_addr);

    // one wait cycle per access, answer on the second cycle
    // the flop idles high, so a new request always waits one cycle
    // and the write lands at the edge where the master sees it low
    assign waitrequest = wait_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~((read | write) & wait_reg);
        end
    end

    // register writes, byte lanes honoured
    // lanes 2 and 3 carry nothing and are ignored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_ctrl_reg <= boost_ctrl_reset;
            enable_rate_reg <= enable_rate_reset;
        end else if (write && !wait_reg) begin
            if (hit_boost && byteenable[0]) begin
                boost_ctrl_reg <= writedata[7:0]; // [R2]
            end
            if (hit_boost && byteenable[1]) begin
                enable_rate_reg <= writedata[15:8]; // [R1] [R3]
            end
            if (hit_rate && byteenable[0]) begin
                enable_rate_reg <= writedata[7:0]; // [R1] [R3]
            end
        end
    end


    // read mux, unmapped reads as zero
    // the status word shows the watchdog state and the pump phase
    always_comb begin
        read_next = 32'h0000_0000;
        if (hit_boost) begin
            read_next = {16'h0000, enable_rate_reg, boost_ctrl_reg}; // [R2]
        end else if (hit_rate) begin
            read_next = {24'h00_0000, enable_rate_reg};
        end else if (hit_status) begin
            read_next = {30'h0000_0000, boost_phase, watchdog_enable};
        end
    end


    // read data registered in the waiting cycle, so it stands
    // unchanged at the edge where waitrequest is low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && wait_reg) begin
            readdata <= read_next;
        end
    end

    // pin synchronisers; first stage read only by the second
    // both pins are asynchronous to sys_clk; a metastable first
    // stage must never reach logic directly
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cclk_sync <= 3'b000;
            strap_sync <= 2'b00;
        end else begin
            cclk_sync <= {cclk_sync[1:0], converter_clock};
            strap_sync <= {strap_sync[0], watchdog_strap_pin};
        end
    end


    // rising edge of the converter clock, from settled stages only
    assign cclk_rise = cclk_sync[1] & ~cclk_sync[2];

    // watchdog off while strap high
    // the strap is sensed as a level; latency is three clocks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_enable <= 1'b0;
        end else begin
            watchdog_enable <= ~strap_sync[1]; // [R6]
        end
    end


    // base divider: converter clock rising edges / 128
    // the converter clock must stay below half of sys_clk,
    // otherwise edges are lost and the display rate runs slow
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt <= 7'h00;
            base_tick <= 1'b0;
        end else begin
            base_tick <= 1'b0;
            if (cclk_rise) begin
                base_cnt <= base_cnt + 7'h01; // [R3] [R4]
                if (base_cnt == 7'(base_div - 1)) begin
                    base_tick <= 1'b1;
                end
            end
        end
    end


    // selectable 2^(9-code) division of the base rate
    // the mask keeps only the low bits that the selected rate uses;
    // after a code change the first period may be short, never stuck
    assign rate_mask = rate_exp_max'((1 << (rate_exp_max - 32'(display_rate_select))) - 1);

    // rate counter: one display tick per masked wrap
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt <= '0;
            display_tick <= 1'b0;
        end else begin
            display_tick <= 1'b0;
            if (base_tick) begin
                if ((rate_cnt & rate_mask) == rate_mask) begin
                    rate_cnt <= '0;
                    display_tick <= 1'b1; // [R3]
                end else begin
                    rate_cnt <= rate_cnt + 1'b1;
                end
            end
        end
    end


    // boost pump drive: square wave from converter clock while enabled
    // clearing the enable parks the phase low, so the pump capacitor
    // is not left charged by a stuck drive level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_cnt <= 4'h0;
            boost_phase <= 1'b0;
        end else if (!display_boost_enable) begin
            boost_cnt <= 4'h0;
            boost_phase <= 1'b0; // [R2]
        end else if (cclk_rise) begin
            if (boost_cnt == 4'(boost_half_div - 1)) begin
                boost_cnt <= 4'h0;
                boost_phase <= ~boost_phase; // [R8]
            end else begin
                boost_cnt <= boost_cnt + 4'h1;
            end
        end
    end


    // drive pin registered, low whenever the pump is off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_drive_pin <= 1'b0;
        end else begin
            boost_drive_pin <= boost_phase & display_boost_enable; // [R8]
        end
    end


    // output gating to ground while disabled
    // registered, so gating follows the enable bit one clock late;
    // all three rails and every common and segment line go low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            com_out <= '0;
            seg_out <= '0;
            bias_rail_top <= 1'b0;
            bias_rail_mid <= 1'b0;
            bias_rail_low <= 1'b0;
        end else begin
            com_out <= display_output_enable ? com_raw : '0; // [R1]
            seg_out <= display_output_enable ? seg_raw : '0; // [R1]
            bias_rail_top <= display_output_enable & bias_raw[2]; // [R1]
            bias_rail_mid <= display_output_enable & bias_raw[1];
            bias_rail_low <= display_output_enable & bias_raw[0];
        end
    end
endmodule : disp_ctrl

// ### testbench/disp_ctrl_monitor.sv
// port assertions for disp_ctrl
// assumes one clock domain, bound into every disp_ctrl
`timescale 1ns/1ps
module disp_ctrl_monitor #(parameter int num_com = 4, parameter int num_seg = 32) (
    // clock, reset and bus
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // drive and status
    input wire logic watchdog_strap_pin,
    input wire logic [num_com-1:0] com_raw,
    input wire logic [num_seg-1:0] seg_raw,
    input wire logic [2:0] bias_raw,
    input wire logic [num_com-1:0] com_out,
    input wire logic [num_seg-1:0] seg_out,
    input wire logic bias_rail_top,
    input wire logic bias_rail_mid,
    input wire logic bias_rail_low,
    input wire logic watchdog_enable,
    input wire logic display_tick
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // steps of a bus access and of strap settling
    sequence req_held; (read || write) && waitrequest; endsequence
    sequence strap_low; !watchdog_strap_pin [*4]; endsequence
    sequence strap_high; watchdog_strap_pin [*4]; endsequence
    bus_answer_a: assert property (req_held |=> !waitrequest)
        else $error("bus answer late");
    gate_com_a: assert property (com_out != '0 |-> com_out == $past(com_raw))
        else $error("commons not a gated copy");
    gate_seg_a: assert property (seg_out != '0 |-> seg_out == $past(seg_raw))
        else $error("segments not a gated copy");
    gate_bias_a: assert property ((bias_rail_top || bias_rail_low) |-> $past(bias_raw) != 0)
        else $error("bias rail without drive");
    tick_pulse_a: assert property (display_tick |=> !display_tick [*8])
        else $error("rate tick too long or too fast");
    wdog_on_a: assert property (strap_low |=> watchdog_enable)
        else $error("watchdog not enabled");
    wdog_off_a: assert property (strap_high |=> !watchdog_enable)
        else $error("watchdog not held off");
endmodule : disp_ctrl_monitor

bind disp_ctrl disp_ctrl_monitor #(.num_com(num_com), .num_seg(num_seg)) mon (.*);

// ### testbench/panel_model.sv
// display panel stand-in: says whether every drive line is grounded
// assumes lines come straight from the block
`timescale 1ns/1ps
module panel_model #(parameter int num_com = 4, parameter int num_seg = 32) (
    // drive from the block
    input wire logic [num_com-1:0] com_out,
    input wire logic [num_seg-1:0] seg_out,
    input wire logic bias_rail_top,
    input wire logic bias_rail_mid,
    input wire logic bias_rail_low,
    // status to the bench
    output logic dark
);
    // blank when all lines sit at ground
    assign dark = ~|{com_out, seg_out, bias_rail_top, bias_rail_mid, bias_rail_low};
endmodule : panel_model

// ### testbench/disp_ctrl_tb.sv
// bench for disp_ctrl: registers, gating, boost, rate, strap
// assumes the panel model and monitor are compiled before it
`timescale 1ns/1ps
module disp_ctrl_tb;
    import disp_ctrl_pkg::*;
    logic sys_clk = 0, rst_n = 0, read = 0, write = 0, watchdog_strap_pin = 1;
    logic [15:0] address = 0;
    logic [3:0] byteenable = 4'h3;
    logic [31:0] writedata = 0, readdata, q;
    logic [3:0] com_raw = 4'h5, com_out;
    logic [31:0] seg_raw = 32'h1234_5678, seg_out;
    logic [2:0] bias_raw = 3'h7;
    logic [1:0] cdiv = 0;
    logic waitrequest, converter_clock, bias_rail_top, bias_rail_mid, bias_rail_low;
    logic boost_drive_pin, watchdog_enable, display_tick, dark, p;
    int n_fail = 0, samples_checked = 0, i, n;
    disp_ctrl dut (.*);
    panel_model panel (.*);
    // clocks: converter clock at a quarter of sys_clk
    assign converter_clock = cdiv[1];
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cdiv <= cdiv + 2'h1;
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // one avalon access, held until waitrequest low
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= d;
        // sample at the rising edge itself: values seen are those before the edge
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            n_fail++;
            wrap_up();
        end
        q = readdata;
        write <= 0;
        read <= 0;
    endtask : bus
    task automatic t_reset;
        bus(0, boost_ctrl_addr, 0); chk("regs", 0, q);
        bus(0, status_addr, 0); chk("wdog", 0, q[0]);
        chk("dark", 1, dark);
        $display("reset test done");
    endtask : t_reset
    task automatic t_gate;
        bus(1, boost_ctrl_addr, 32'h0000_2100);
        repeat (2) @(negedge sys_clk);
        chk("com", com_raw, com_out);
        chk("seg", seg_raw, seg_out);
        chk("bias", bias_raw, {bias_rail_top, bias_rail_mid, bias_rail_low});
        bus(0, enable_rate_word_addr, 0); chk("alias", 8'h21, q[7:0]);
        bus(1, enable_rate_word_addr, 32'h0000_0001);
        repeat (2) @(negedge sys_clk);
        chk("dark", 1, dark);
        $display("gate test done");
    endtask : t_gate
    task automatic t_boost;
        bus(1, boost_ctrl_addr, 32'h0000_2180);
        bus(0, boost_ctrl_addr, 0); chk("boost", 32'h0000_2180, q);
        n = 0;
        p = 0;
        for (i = 0; i < 200; i++) begin
            @(negedge sys_clk);
            if (boost_drive_pin === 1'b1 && !p) n++;
            p = boost_drive_pin;
        end
        chk("edges", 1, n >= 2);
        bus(1, boost_ctrl_addr, 32'h0000_2100);
        repeat (40) @(negedge sys_clk);
        chk("pin", 0, boost_drive_pin);
        $display("boost test done");
    endtask : t_boost
    task automatic t_wdog;
        @(posedge sys_clk);
        watchdog_strap_pin <= 0;
        repeat (5) @(negedge sys_clk);
        chk("wdog", 1, watchdog_enable);
        bus(0, status_addr, 0); chk("stat", 1, q[0]);
        watchdog_strap_pin <= 1;
        repeat (5) @(negedge sys_clk);
        chk("wdog", 0, watchdog_enable);
        bus(0, 16'h2030, 0); chk("unmapped", 0, q);
        $display("strap test done");
    endtask : t_wdog
    task automatic t_rate;
        for (i = 0; i < 4; i++) begin
            bus(1, boost_ctrl_addr, {16'h0, 6'h08, i[1:0], 8'h00});
            bus(0, boost_ctrl_addr, 0); chk("rate", i, q[9:8]);
        end
        for (n = 0; n < 40000 && display_tick !== 1'b1; n++) @(negedge sys_clk);
        chk("first tick", 1, n < 40000);
        for (n = 1; n < 40000; n++) begin
            @(negedge sys_clk);
            if (display_tick === 1'b1) break;
        end
        chk("period", base_div * 2 ** (rate_exp_max - 3) * 4, n);
        $display("rate test done");
    endtask : t_rate
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1;
        t_reset();
        t_gate();
        t_boost();
        t_wdog();
        t_rate();
        wrap_up();
    end
endmodule : disp_ctrl_tb
